// file: rtl/dpt_pkg.sv
package dpt_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int PRE_W  = 6;
    localparam int CNT_W  = 8;

    // printed offsets are register indices; byte address is four times the index
    localparam logic [15:0] IDX_CTRL  = 16'hFE3C;
    localparam logic [15:0] IDX_PER1  = 16'hFE3E;
    localparam logic [15:0] IDX_PER2  = 16'hFE3F;
    localparam logic [15:0] IDX_ISTAT = 16'hFE40;
    localparam logic [15:0] IDX_IMASK = 16'hFE41;
    localparam logic [15:0] IDX_COUNT = 16'hFE42;

    localparam int F_IE1  = 0;
    localparam int F_OVF1 = 1;
    localparam int F_IE2  = 2;
    localparam int F_OVF2 = 3;
    localparam int F_SEL1 = 4;
    localparam int F_SEL2 = 6;

    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PER_RST  = 8'h00;
    localparam logic [1:0] IRQ_RST  = 2'h0;

    localparam logic [PRE_W-1:0] TICK_4  = 6'h03;
    localparam logic [PRE_W-1:0] TICK_16 = 6'h0F;
    localparam logic [PRE_W-1:0] TICK_64 = 6'h3F;

    typedef enum logic [1:0] {
        SEL_STOP = 2'b00,
        SEL_4    = 2'b01,
        SEL_16   = 2'b10,
        SEL_64   = 2'b11
    } dpt_sel_t;

    function automatic logic dpt_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        return a == {idx, 2'b00};
    endfunction : dpt_hit

endpackage : dpt_pkg

// file: rtl/dpt_ch_if.sv
`timescale 1ns/1ps
interface dpt_ch_if;
    dpt_pkg::dpt_sel_t          sel;
    logic                       clr;
    logic [dpt_pkg::CNT_W-1:0]  period;
    logic                       tick;
    logic [dpt_pkg::PRE_W-1:0]  pre;
    logic [dpt_pkg::CNT_W-1:0]  cnt;
    logic                       wrap;

    modport ctl (output sel, clr, period, input tick, pre, cnt, wrap);
    modport psc (input sel, clr, output tick, pre);
    modport ctr (input sel, clr, period, tick, output cnt, wrap);
endinterface : dpt_ch_if

// file: rtl/dpt_prescaler.sv
`timescale 1ns/1ps
module dpt_prescaler #(
    parameter int PW = dpt_pkg::PRE_W
) (
    input  wire logic pclk,
    input  wire logic presetn,
    dpt_ch_if.psc     ch
);
    typedef struct packed {
        logic [PW-1:0] pre;
    } dpt_psc_st_t;

    dpt_psc_st_t st_q;
    dpt_psc_st_t st_d;

    function automatic logic dpt_tick_of(input logic [PW-1:0] p, input dpt_pkg::dpt_sel_t s);
        case (s)
            dpt_pkg::SEL_4:  return (p & dpt_pkg::TICK_4) == dpt_pkg::TICK_4;
            dpt_pkg::SEL_16: return (p & dpt_pkg::TICK_16) == dpt_pkg::TICK_16;
            dpt_pkg::SEL_64: return p == dpt_pkg::TICK_64;
            default:         return 1'b0;
        endcase
    endfunction : dpt_tick_of

    always_comb begin
        st_d = st_q;
        if (ch.sel == dpt_pkg::SEL_STOP || ch.clr) begin
            st_d.pre = '0; // [R8] [R6]
        end else begin
            st_d.pre = st_q.pre + {{(PW-1){1'b0}}, 1'b1}; // [R7]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ch.pre  = st_q.pre;
    assign ch.tick = dpt_tick_of(st_q.pre, ch.sel); // [R1] [R8]

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_run4;
        (ch.sel == dpt_pkg::SEL_4 && !ch.clr)[*4];
    endsequence

    a_tick_every_four: assert property ( // [R8]
        (ch.tick && ch.sel == dpt_pkg::SEL_4 && !ch.clr) ##1 s_run4 |-> ch.tick && $past(!ch.tick)
    ) else $error("4-cycle count clock period wrong");

    a_stop_holds_pre: assert property ( // [R7]
        ch.sel == dpt_pkg::SEL_STOP |=> ch.pre == '0 && !ch.tick
    ) else $error("stopped prescaler not held at zero");
endmodule : dpt_prescaler

// file: rtl/dpt_counter.sv
`timescale 1ns/1ps
module dpt_counter #(
    parameter int CW = dpt_pkg::CNT_W
) (
    input  wire logic pclk,
    input  wire logic presetn,
    dpt_ch_if.ctr     ch
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic          wrap;
    } dpt_ctr_st_t;

    dpt_ctr_st_t st_q;
    dpt_ctr_st_t st_d;

    always_comb begin
        st_d      = st_q;
        st_d.wrap = 1'b0;
        if (ch.sel == dpt_pkg::SEL_STOP || ch.clr) begin
            st_d.cnt = '0; // [R4] [R5] [R6]
        end else if (ch.tick) begin
            if (st_q.cnt == ch.period) begin
                st_d.cnt  = '0; // [R3]
                st_d.wrap = 1'b1; // [R10]
            end else begin
                st_d.cnt = st_q.cnt + {{(CW-1){1'b0}}, 1'b1}; // [R3]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ch.cnt  = st_q.cnt;
    assign ch.wrap = st_q.wrap;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_wrap_at_period: assert property ( // [R3]
        ch.tick && !ch.clr && ch.sel != dpt_pkg::SEL_STOP && ch.cnt == ch.period
        |=> ch.cnt == '0 && ch.wrap
    ) else $error("counter did not wrap at period value");

    a_count_step: assert property ( // [R1]
        ch.tick && !ch.clr && ch.sel != dpt_pkg::SEL_STOP && ch.cnt != ch.period
        |=> ch.cnt == $past(ch.cnt) + 8'h01 && !ch.wrap
    ) else $error("counter did not advance on count clock");
endmodule : dpt_counter

// file: rtl/dpt_timer_top.sv
`timescale 1ns/1ps
// Operation
// [R1] each timer counts on a 4, 16 or 64 cycle count clock; period is (period+1) count clocks
// [R2] the interrupt is raised while a timer's overflow flag and its enable are both set
// [R3] a counter steps on each count clock and on the clock after matching the period goes to 0
// [R4] first timer select bits 5:4 at zero hold its counter at zero, else it counts
// [R5] second timer select bits 7:6 at zero hold its counter at zero, else it counts
// [R6] writing a period register clears that timer's prescaler and counter and restarts it
// [R7] each timer has its own 6-bit prescaler running from the cycle clock
// [R8] select code 00 holds in reset, 01 gives 4, 10 gives 16 and 11 gives 64 cycles
// [R9] each timer has an 8-bit writable period register; control and periods reset to zero
// [R10] an overflow flag is set once per period while running and only software clears it
// [R11] first timer flag and enable sit at control bits 1 and 0, second timer at 3 and 2
// [R12] a hardware flag set in the same cycle as a software clear wins
module dpt_timer_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [dpt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [dpt_pkg::DATA_W-1:0] pwdata,
    output      logic [dpt_pkg::DATA_W-1:0] prdata,
    output      logic                       pready,
    output      logic                       pslverr,
    output      logic                       irq
);
    typedef struct packed {
        logic [7:0]                  ctrl;
        logic [7:0]                  per1;
        logic [7:0]                  per2;
        logic [1:0]                  stat;
        logic [1:0]                  mask;
        logic [dpt_pkg::DATA_W-1:0]  rdata;
        logic                        ready;
        logic                        err;
        logic                        irq;
    } dpt_top_st_t;

    dpt_top_st_t q;
    dpt_top_st_t d;

    dpt_ch_if ch1 ();
    dpt_ch_if ch2 ();

    logic acc_first;
    logic wr_en;
    logic wr_ctrl;
    logic wr_per1;
    logic wr_per2;
    logic wr_stat;
    logic wr_mask;
    logic mapped;

    // one wait state: data and error are prepared in the first access
    // cycle, so the completing edge never sees a half-decoded answer
    assign acc_first = psel && penable && !q.ready;
    assign wr_en     = psel && penable && q.ready && pwrite;

    assign wr_ctrl = wr_en && dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_CTRL);
    assign wr_per1 = wr_en && dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_PER1);
    assign wr_per2 = wr_en && dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_PER2);
    assign wr_stat = wr_en && dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_ISTAT);
    assign wr_mask = wr_en && dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_IMASK);

    assign mapped = dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_CTRL)
                 || dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_PER1)
                 || dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_PER2)
                 || dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_ISTAT)
                 || dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_IMASK)
                 || dpt_pkg::dpt_hit(paddr, dpt_pkg::IDX_COUNT);

    assign ch1.sel    = dpt_pkg::dpt_sel_t'(q.ctrl[dpt_pkg::F_SEL1 +: 2]); // [R4]
    assign ch2.sel    = dpt_pkg::dpt_sel_t'(q.ctrl[dpt_pkg::F_SEL2 +: 2]); // [R5]
    assign ch1.period = q.per1;
    assign ch2.period = q.per2;
    // any period write restarts; while stopped the pair sits at zero anyway
    assign ch1.clr    = wr_per1; // [R6]
    assign ch2.clr    = wr_per2; // [R6]

    dpt_prescaler #(
        .PW (dpt_pkg::PRE_W)
    ) u_psc1 (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch1)
    );

    dpt_prescaler #(
        .PW (dpt_pkg::PRE_W)
    ) u_psc2 (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch2)
    );

    dpt_counter #(
        .CW (dpt_pkg::CNT_W)
    ) u_ctr1 (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch1)
    );

    dpt_counter #(
        .CW (dpt_pkg::CNT_W)
    ) u_ctr2 (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch2)
    );

    function automatic logic [dpt_pkg::DATA_W-1:0] dpt_rd(
        input logic [dpt_pkg::ADDR_W-1:0] a,
        input dpt_top_st_t                s,
        input logic [7:0]                 c1,
        input logic [7:0]                 c2
    );
        logic [dpt_pkg::DATA_W-1:0] r;
        r = '0;
        if (dpt_pkg::dpt_hit(a, dpt_pkg::IDX_CTRL)) begin
            r[7:0] = s.ctrl;
        end else if (dpt_pkg::dpt_hit(a, dpt_pkg::IDX_PER1)) begin
            r[7:0] = s.per1;
        end else if (dpt_pkg::dpt_hit(a, dpt_pkg::IDX_PER2)) begin
            r[7:0] = s.per2;
        end else if (dpt_pkg::dpt_hit(a, dpt_pkg::IDX_ISTAT)) begin
            r[1:0] = s.stat;
        end else if (dpt_pkg::dpt_hit(a, dpt_pkg::IDX_IMASK)) begin
            r[1:0] = s.mask;
        end else if (dpt_pkg::dpt_hit(a, dpt_pkg::IDX_COUNT)) begin
            r[15:0] = {c2, c1};
        end
        return r;
    endfunction : dpt_rd

    always_comb begin
        d = q;

        d.ready = acc_first;
        // error is a one-cycle pulse beside pready, never left standing
        d.err   = acc_first && !mapped;
        if (acc_first) begin
            d.rdata = pwrite ? '0 : dpt_rd(paddr, q, ch1.cnt, ch2.cnt);
        end

        if (wr_ctrl) begin
            d.ctrl = pwdata[7:0]; // [R9]
        end
        if (wr_per1) begin
            d.per1 = pwdata[7:0]; // [R9]
        end
        if (wr_per2) begin
            d.per2 = pwdata[7:0]; // [R9]
        end
        if (wr_mask) begin
            d.mask = pwdata[1:0];
        end

        // set is applied after the write so a coinciding clear loses
        if (ch1.wrap) begin
            d.ctrl[dpt_pkg::F_OVF1] = 1'b1; // [R10] [R11] [R12]
        end
        if (ch2.wrap) begin
            d.ctrl[dpt_pkg::F_OVF2] = 1'b1; // [R10] [R11] [R12]
        end

        d.stat = (q.stat & ~(wr_stat ? pwdata[1:0] : 2'h0)) | {ch2.wrap, ch1.wrap}; // [R12]

        d.irq = (d.ctrl[dpt_pkg::F_OVF1] && d.ctrl[dpt_pkg::F_IE1]) // [R2] [R11]
             || (d.ctrl[dpt_pkg::F_OVF2] && d.ctrl[dpt_pkg::F_IE2]) // [R2] [R11]
             || (|(d.stat & d.mask));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q.ctrl  <= dpt_pkg::CTRL_RST;
            q.per1  <= dpt_pkg::PER_RST;
            q.per2  <= dpt_pkg::PER_RST;
            q.stat  <= dpt_pkg::IRQ_RST;
            q.mask  <= dpt_pkg::IRQ_RST;
            q.rdata <= '0;
            q.ready <= 1'b0;
            q.err   <= 1'b0;
            q.irq   <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign prdata  = q.rdata;
    assign pready  = q.ready;
    assign pslverr = q.err;
    assign irq     = q.irq;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_clear_ovf1;
        wr_ctrl && !pwdata[dpt_pkg::F_OVF1];
    endsequence

    sequence s_clear_ovf2;
        wr_ctrl && !pwdata[dpt_pkg::F_OVF2];
    endsequence

    a_reset_zero: assert property ( // [R9]
        $rose(presetn) |-> q.ctrl == 8'h00 && q.per1 == 8'h00 && q.per2 == 8'h00
    ) else $error("control or period not zero after reset");

    a_first_flag_set: assert property ( // [R10]
        ch1.wrap |=> q.ctrl[dpt_pkg::F_OVF1] && q.stat[0]
    ) else $error("first timer overflow did not set its flag");

    a_second_flag_set: assert property ( // [R11]
        ch2.wrap |=> q.ctrl[dpt_pkg::F_OVF2] && q.stat[1]
    ) else $error("second timer overflow did not set bit 3");

    a_flag_sticky: assert property ( // [R10]
        q.ctrl[dpt_pkg::F_OVF1] && !(wr_ctrl && !pwdata[dpt_pkg::F_OVF1])
        |=> q.ctrl[dpt_pkg::F_OVF1]
    ) else $error("first overflow flag dropped without software");

    a_set_wins_clear: assert property ( // [R12]
        (s_clear_ovf2 and ch2.wrap) |=> q.ctrl[dpt_pkg::F_OVF2]
    ) else $error("overflow lost to a coinciding clear");

    a_irq_enable: assert property ( // [R2]
        (q.ctrl[dpt_pkg::F_OVF1] && q.ctrl[dpt_pkg::F_IE1]) ##1
        (q.ctrl[dpt_pkg::F_OVF1] && q.ctrl[dpt_pkg::F_IE1]) |-> irq
    ) else $error("enabled overflow did not raise interrupt");

    a_irq_quiet: assert property ( // [R2]
        !(q.ctrl[dpt_pkg::F_OVF1] && q.ctrl[dpt_pkg::F_IE1])
        && !(q.ctrl[dpt_pkg::F_OVF2] && q.ctrl[dpt_pkg::F_IE2])
        && !(|(q.stat & q.mask)) |-> !irq
    ) else $error("interrupt with no enabled source");

    a_first_halt: assert property ( // [R4]
        ch1.sel == dpt_pkg::SEL_STOP |=> ch1.cnt == 8'h00 && ch1.pre == 6'h00
    ) else $error("first timer not held at zero when stopped");

    a_second_halt: assert property ( // [R5]
        ch2.sel == dpt_pkg::SEL_STOP |=> ch2.cnt == 8'h00 && ch2.pre == 6'h00
    ) else $error("second timer not held at zero when stopped");

    a_period_restart: assert property ( // [R6]
        wr_per1 |=> ch1.cnt == 8'h00 && ch1.pre == 6'h00 && q.per1 == $past(pwdata[7:0])
    ) else $error("period write did not restart first timer");

    a_apb_one_wait: assert property (
        (psel && penable && !pready) |=> pready ##1 !pready
    ) else $error("bus answer not one wait state");

    a_unmapped_err: assert property (
        (psel && penable && !pready && !mapped) |=> pslverr && pready
    ) else $error("unmapped access not flagged");

    a_mapped_no_err: assert property (
        (psel && penable && !pready && mapped) |=> !pslverr && pready
    ) else $error("mapped access flagged as error");

    a_rdata_hold: assert property (
        !acc_first |=> $stable(prdata)
    ) else $error("read data changed outside an access");

    // flag bookkeeping: only a wrap or a software write may move a flag
    a_first_set_wins: assert property ( // [R12]
        (s_clear_ovf1 and ch1.wrap) |=> q.ctrl[dpt_pkg::F_OVF1]
    ) else $error("first overflow lost to a coinciding clear");

    a_second_sticky: assert property ( // [R10]
        q.ctrl[dpt_pkg::F_OVF2] && !(wr_ctrl && !pwdata[dpt_pkg::F_OVF2])
        |=> q.ctrl[dpt_pkg::F_OVF2]
    ) else $error("second overflow flag dropped without software");

    a_first_sw_clear: assert property ( // [R10]
        s_clear_ovf1 ##0 !ch1.wrap |=> !q.ctrl[dpt_pkg::F_OVF1]
    ) else $error("software clear of first flag ignored");

    a_second_sw_clear: assert property ( // [R10]
        s_clear_ovf2 ##0 !ch2.wrap |=> !q.ctrl[dpt_pkg::F_OVF2]
    ) else $error("software clear of second flag ignored");

    a_first_no_stray: assert property ( // [R10]
        !q.ctrl[dpt_pkg::F_OVF1] && !ch1.wrap && !(wr_ctrl && pwdata[dpt_pkg::F_OVF1])
        |=> !q.ctrl[dpt_pkg::F_OVF1]
    ) else $error("first flag set with no overflow");

    a_second_no_stray: assert property ( // [R10]
        !q.ctrl[dpt_pkg::F_OVF2] && !ch2.wrap && !(wr_ctrl && pwdata[dpt_pkg::F_OVF2])
        |=> !q.ctrl[dpt_pkg::F_OVF2]
    ) else $error("second flag set with no overflow");

    a_first_wrap_once: assert property ( // [R10]
        ch1.wrap |=> !ch1.wrap
    ) else $error("first timer wrapped on two cycles in a row");

    a_second_wrap_once: assert property ( // [R10]
        ch2.wrap |=> !ch2.wrap
    ) else $error("second timer wrapped on two cycles in a row");

    a_first_wrap_run: assert property ( // [R4]
        ch1.wrap |-> $past(ch1.sel != dpt_pkg::SEL_STOP)
    ) else $error("first timer overflowed while stopped");

    a_second_wrap_run: assert property ( // [R5]
        ch2.wrap |-> $past(ch2.sel != dpt_pkg::SEL_STOP)
    ) else $error("second timer overflowed while stopped");

    a_irq_second: assert property ( // [R2]
        q.ctrl[dpt_pkg::F_OVF2] && q.ctrl[dpt_pkg::F_IE2] |-> irq
    ) else $error("enabled second overflow did not raise interrupt");

    a_irq_status: assert property (
        (|(q.stat & q.mask)) |-> irq
    ) else $error("unmasked status bit did not raise interrupt");

    a_second_restart: assert property ( // [R6]
        wr_per2 |=> ch2.cnt == 8'h00 && ch2.pre == 6'h00 && q.per2 == $past(pwdata[7:0])
    ) else $error("period write did not restart second timer");

    a_first_per_hold: assert property ( // [R9]
        !wr_per1 |=> $stable(q.per1)
    ) else $error("first period changed without a write");

    a_second_per_hold: assert property ( // [R9]
        !wr_per2 |=> $stable(q.per2)
    ) else $error("second period changed without a write");

    a_ctrl_write: assert property ( // [R9]
        wr_ctrl && !ch1.wrap && !ch2.wrap |=> q.ctrl == $past(pwdata[7:0])
    ) else $error("control write not stored");

    a_ctrl_hold: assert property ( // [R10]
        !wr_ctrl && !ch1.wrap && !ch2.wrap |=> $stable(q.ctrl)
    ) else $error("control changed with no write or overflow");

endmodule : dpt_timer_top

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic                       pclk;
    logic                       presetn;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [dpt_pkg::ADDR_W-1:0] paddr;
    logic [dpt_pkg::DATA_W-1:0] pwdata;
    logic [dpt_pkg::DATA_W-1:0] prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       irq;
    int                         n_mismatch;
    int                         compares;
    int                         cyc;
    int                         rise_q[$];
    logic                       irq_prev;
    logic [31:0]                rd;
    logic                       err;
    int                         tw;
    int                         d;
    logic [7:0]                 ctrl;
    logic [7:0]                 flag_tab[6] = '{8'h02, 8'h03, 8'h08, 8'h0C, 8'h0F, 8'h0A};
    logic                       irq_tab[6]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    dpt_timer_top dpt_timer_top_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .irq     (irq)
    );

    always #10 pclk = ~pclk;

    // stamps each rising edge of irq so period gaps are measured in pclk cycles
    always @(posedge pclk) begin
        if (irq === 1'b1 && irq_prev !== 1'b1) rise_q.push_back(cyc);
        irq_prev <= irq;
        cyc      <= cyc + 1;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one transfer; held until pready is seen high at a rising edge
    task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        if (n >= 50) check("pready", 1'b0, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_rises(input int k);
        int n;
        n = 0;
        while (rise_q.size() < k && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (rise_q.size() < k) check("irq rise", 1'b0, 1'b1);
    endtask : wait_rises

    initial begin
        repeat (40000) @(posedge pclk);
        n_mismatch++;
        close_out();
    end

    initial begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; n_mismatch = 0; compares = 0; cyc = 0; irq_prev = 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(dpt_pkg::IDX_CTRL, 1'b0, 8'h00);
        check("ctrl reset", rd, 32'h00000000);
        check("mapped read err", err, 1'b0);
        apb(dpt_pkg::IDX_PER1, 1'b0, 8'h00);
        check("per1 reset", rd, 32'h00000000);
        apb(dpt_pkg::IDX_PER2, 1'b0, 8'h00);
        check("per2 reset", rd, 32'h00000000);
        check("irq reset", irq, 1'b0);
        apb(16'hFE3D, 1'b1, 8'hFF);
        check("unmapped write err", err, 1'b1);
        apb(16'hFE3D, 1'b0, 8'h00);
        check("unmapped read err", err, 1'b1);
        check("unmapped read data", rd, 32'h00000000);
        $display("test reset and map done");

        // select codes 01, 10 and 11 on both timers; gap between flag sets is (P+1)*N
        for (int t = 0; t < 2; t++) begin
            for (int s = 1; s < 4; s++) begin
                ctrl = 8'((s << (4 + 2 * t)) | (1 << (2 * t)));
                apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h00);
                apb(t ? dpt_pkg::IDX_PER2 : dpt_pkg::IDX_PER1, 1'b1, 8'h05);
                apb(t ? dpt_pkg::IDX_PER2 : dpt_pkg::IDX_PER1, 1'b0, 8'h00);
                check("period reg", rd, 32'h00000005);
                rise_q.delete();
                apb(dpt_pkg::IDX_CTRL, 1'b1, ctrl);
                wait_rises(1);
                apb(dpt_pkg::IDX_CTRL, 1'b0, 8'h00);
                check("flag position", rd, 32'(ctrl | (8'h02 << (2 * t))));
                apb(dpt_pkg::IDX_CTRL, 1'b1, ctrl);
                wait_rises(2);
                apb(dpt_pkg::IDX_CTRL, 1'b1, ctrl);
                wait_rises(3);
                check("period gap", 32'(rise_q[2] - rise_q[1]), 32'(6 << (2 * s)));
            end
        end
        $display("test period timing done");

        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h05);
        repeat (300) @(posedge pclk);
        check("irq stopped", irq, 1'b0);
        apb(dpt_pkg::IDX_COUNT, 1'b0, 8'h00);
        check("counters stopped", rd, 32'h00000000);
        apb(dpt_pkg::IDX_COUNT, 1'b1, 8'h55);
        apb(dpt_pkg::IDX_COUNT, 1'b0, 8'h00);
        check("count read only", rd, 32'h00000000);
        for (int i = 0; i < 6; i++) begin
            apb(dpt_pkg::IDX_CTRL, 1'b1, flag_tab[i]);
            @(posedge pclk);
            #1 check("irq gating", irq, irq_tab[i]);
        end
        $display("test stop and gating done");

        // period write mid-run moves the next flag set out to a full period
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h00);
        apb(dpt_pkg::IDX_PER1, 1'b1, 8'h09);
        rise_q.delete();
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h11);
        wait_rises(1);
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h11);
        repeat (20) @(posedge pclk);
        apb(dpt_pkg::IDX_PER1, 1'b1, 8'h09);
        #1 tw = cyc;
        wait_rises(2);
        d = rise_q[1] - tw;
        check("restart gap", (d >= 38 && d <= 43), 1'b1);
        $display("test restart done");

        // clear lands on the edge after the wrap pulse: (5+1)*4 cycles plus one
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h00);
        apb(dpt_pkg::IDX_PER2, 1'b1, 8'h05);
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h40);
        repeat (21) @(posedge pclk);
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h40);
        apb(dpt_pkg::IDX_CTRL, 1'b0, 8'h00);
        check("set beats clear", rd, 32'h00000048);
        $display("test set priority done");

        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h00);
        apb(dpt_pkg::IDX_ISTAT, 1'b1, 8'h03);
        apb(dpt_pkg::IDX_IMASK, 1'b0, 8'h00);
        check("imask reset", rd, 32'h00000000);
        apb(dpt_pkg::IDX_PER1, 1'b1, 8'h05);
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h10);
        repeat (60) @(posedge pclk);
        check("irq masked", irq, 1'b0);
        apb(dpt_pkg::IDX_ISTAT, 1'b0, 8'h00);
        check("istat set", rd, 32'h00000001);
        apb(dpt_pkg::IDX_CTRL, 1'b0, 8'h00);
        check("flag set no ie", rd, 32'h00000012);
        repeat (60) @(posedge pclk);
        apb(dpt_pkg::IDX_CTRL, 1'b0, 8'h00);
        check("flag sticky", rd, 32'h00000012);
        apb(dpt_pkg::IDX_IMASK, 1'b1, 8'h01);
        @(posedge pclk);
        #1 check("irq unmasked", irq, 1'b1);
        apb(dpt_pkg::IDX_CTRL, 1'b1, 8'h00);
        apb(dpt_pkg::IDX_ISTAT, 1'b1, 8'h01);
        apb(dpt_pkg::IDX_ISTAT, 1'b0, 8'h00);
        check("istat cleared", rd, 32'h00000000);
        check("irq cleared", irq, 1'b0);
        $display("test interrupt status done");

        // reset in mid-run must bring written registers back to zero
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(dpt_pkg::IDX_PER1, 1'b0, 8'h00);
        check("per1 after reset", rd, 32'h00000000);
        apb(dpt_pkg::IDX_IMASK, 1'b0, 8'h00);
        check("imask after reset", rd, 32'h00000000);
        $display("test second reset done");
        close_out();
    end
endmodule : tb_top
